// ### verilog/dvp_consts.svh
`ifndef DVP_CONSTS_SVH
`define DVP_CONSTS_SVH

// ****************************************
// Device register offsets
// ****************************************
`define DVP_OFS_PATH      8'h3F
`define DVP_OFS_MUTE      8'h40
`define DVP_OFS_GAIN      8'h41
`define DVP_OFS_SPARE     8'h42

// ****************************************
// Reset values
// ****************************************
`define DVP_RST_PATH      8'h14
`define DVP_RST_MUTE      8'h0C
`define DVP_RST_GAIN      8'h00
`define DVP_RST_SPARE     8'h00

// ****************************************
// Field positions
// ****************************************
`define DVP_BIT_POWER     7
`define DVP_BIT_RSVD6     6
`define DVP_SEL_HI        5
`define DVP_SEL_LO        4
`define DVP_RATE_HI       1
`define DVP_RATE_LO       0
`define DVP_BIT_MUTE      3
`define DVP_MUTE_LOW_RST  3'h4

// ****************************************
// Gain code limits
// ****************************************
`define DVP_GAIN_MAX      8'sh30
`define DVP_GAIN_MIN      8'sh81
`define DVP_GAIN_BIAS     10'sh084
`define DVP_GAIN_OCTAVE   10'sh00C
`define DVP_GAIN_BIAS_OCT 4'hB
`define DVP_MANT_FRAC     14

// ****************************************
// Host controller register offsets
// ****************************************
`define DVP_HOFS_ADDR     8'h00
`define DVP_HOFS_WDATA    8'h01
`define DVP_HOFS_GO       8'h02
`define DVP_HOFS_STATUS   8'h03
`define DVP_HOFS_RDATA    8'h04
`define DVP_GO_WRITE      0
`define DVP_GO_READ       1
`define DVP_ST_BUSY       0
`define DVP_ST_REFUSED    1

`endif

// ### verilog/dvp_pkg.sv
package dvp_pkg;

  typedef enum logic [1:0] {
    DVP_PATH_OFF   = 2'b00,
    DVP_PATH_LEFT  = 2'b01,
    DVP_PATH_RIGHT = 2'b10,
    DVP_PATH_AVG   = 2'b11
  } dvp_path_t;

  typedef enum logic [1:0] {
    DVP_RATE_ONE   = 2'b00,
    DVP_RATE_TWO   = 2'b01,
    DVP_RATE_NOW   = 2'b10,
    DVP_RATE_RSVD  = 2'b11
  } dvp_rate_t;

  typedef enum logic [1:0] {
    DVP_HST_IDLE   = 2'b00,
    DVP_HST_RDWAIT = 2'b01,
    DVP_HST_RDCAP  = 2'b10
  } dvp_hst_state_t;

  typedef logic [7:0] dvp_byte_t;

endpackage

// ### verilog/dvp_link_if.sv
`timescale 1ns/1ps

interface dvp_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;

  modport dev (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata
  );

  modport hst (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata
  );
endinterface

// ### verilog/dvp_fifo.sv
`timescale 1ns/1ps

module dvp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_params
    $error("dvp_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire              push       = in_valid && in_ready;
  wire              pop        = out_valid && out_ready;
  wire [AW:0]       next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Ready is registered so that it can leave the top straight from a flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_ptr   <= wr_ptr + AW'(push);
      rd_ptr   <= rd_ptr + AW'(pop);
      count    <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule

// ### verilog/dvp_dev.sv
// What this block does
// RL1 - Power bit D7 powers the DAC, resets off
// RL2 - Path select: off, left, right, average; resets left
// RL3 - Step rate: per sample, per two, immediate
// RL4 - Host never writes reserved rate code 11
// RL5 - Host writes zero to path bit D6
// RL6 - Mute bit D3 silences output, resets muted
// RL7 - Host keeps mute reserved bits at reset pattern
// RL8 - Gain is signed half-dB code, resets zero
// RL9 - Host never writes reserved gain codes
// RL10 - Host writes only zero to spare register
// RL11 - Soft-step applied gain one step toward target
// RL12 - Path bits D3-D2 are plain storage, reset 01
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "dvp_consts.svh"

module dvp_dev #(
  parameter int SW    = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  dvp_link_if.dev               link,
  input  wire logic [SW-1:0]    aud_left,
  input  wire logic [SW-1:0]    aud_right,
  input  wire logic             aud_valid,
  output logic                  aud_ready,
  input  wire logic             sample_tick,
  output logic [SW-1:0]         dac_sample,
  output logic                  dac_valid,
  output logic                  dac_power,
  output dvp_pkg::dvp_byte_t    applied_gain
);
  import dvp_pkg::*;

  if (SW < 2 || SW > 24) begin : g_bad_sw
    $error("dvp_dev: SW must lie between 2 and 24");
  end

  // Saturation limits at the width of the gain product
  localparam logic signed [SW+20:0] SAT_HI = {22'h0, {(SW-1){1'b1}}};
  localparam logic signed [SW+20:0] SAT_LO = ~SAT_HI;

  // ****************************************
  // Gain arithmetic
  // ****************************************
  function automatic logic signed [15:0] mant(input logic [3:0] r);
    logic signed [15:0] m;
    m = 16'sh4000;
    unique case (r)
      4'h0:    m = 16'sh4000;
      4'h1:    m = 16'sh43CE;
      4'h2:    m = 16'sh47D6;
      4'h3:    m = 16'sh4C1C;
      4'h4:    m = 16'sh50A3;
      4'h5:    m = 16'sh556E;
      4'h6:    m = 16'sh5A82;
      4'h7:    m = 16'sh5FE4;
      4'h8:    m = 16'sh6598;
      4'h9:    m = 16'sh6BA2;
      4'hA:    m = 16'sh7209;
      4'hB:    m = 16'sh78D1;
      default: m = 16'sh4000;
    endcase
    return m;
  endfunction

  // Half-dB code to linear factor: octave shift times a twelfth-root mantissa
  function automatic logic [SW-1:0] apply_gain(input logic [SW-1:0] s,
                                               input logic [7:0]    g);
    logic signed [9:0]     u;
    logic [3:0]            q;
    logic [3:0]            r;
    logic signed [SW+20:0] x;
    u = 10'(signed'(g)) + `DVP_GAIN_BIAS;
    q = 4'(u / `DVP_GAIN_OCTAVE);
    r = 4'(u % `DVP_GAIN_OCTAVE);
    x = (SW+21)'(signed'(s)) * (SW+21)'(mant(r));
    if (q >= `DVP_GAIN_BIAS_OCT) begin
      x = x <<< (q - `DVP_GAIN_BIAS_OCT);
    end else begin
      x = x >>> (`DVP_GAIN_BIAS_OCT - q);
    end
    x = x >>> `DVP_MANT_FRAC;
    if (x > SAT_HI) begin
      x = SAT_HI;
    end else if (x < SAT_LO) begin
      x = SAT_LO;
    end
    return SW'(x);
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  dvp_byte_t path_setup;
  dvp_byte_t mute_control;
  dvp_byte_t digital_gain;
  dvp_byte_t spare;

  wire       hit_path  = (link.addr == `DVP_OFS_PATH);
  wire       hit_mute  = (link.addr == `DVP_OFS_MUTE);
  wire       hit_gain  = (link.addr == `DVP_OFS_GAIN);
  wire       hit_spare = (link.addr == `DVP_OFS_SPARE);
  wire [7:0] read_mux  = hit_path  ? path_setup   :
                         hit_mute  ? mute_control :
                         hit_gain  ? digital_gain :
                         hit_spare ? spare        : 8'h00;

  // Reserved bits, including D3-D2 of path setup, are stored as written
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      path_setup   <= `DVP_RST_PATH; // RL1 RL2 RL3 RL12
      mute_control <= `DVP_RST_MUTE; // RL6
      digital_gain <= `DVP_RST_GAIN; // RL8
      spare        <= `DVP_RST_SPARE;
    end else if (link.wr) begin
      if (hit_path)  path_setup   <= link.wdata;
      if (hit_mute)  mute_control <= link.wdata;
      if (hit_gain)  digital_gain <= link.wdata;
      if (hit_spare) spare        <= link.wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.rdata <= 8'h00;
    end else begin
      link.rdata <= link.rd ? read_mux : 8'h00;
    end
  end

  // ****************************************
  // Controls decoded from registers
  // ****************************************
  dvp_path_t path_sel;
  dvp_rate_t step_rate;
  wire       power_on = path_setup[`DVP_BIT_POWER];
  wire       muted    = mute_control[`DVP_BIT_MUTE];

  assign path_sel  = dvp_path_t'(path_setup[`DVP_SEL_HI:`DVP_SEL_LO]);
  assign step_rate = dvp_rate_t'(path_setup[`DVP_RATE_HI:`DVP_RATE_LO]);

  // ****************************************
  // Soft-stepping of the applied gain
  // ****************************************
  logic      half_phase;
  wire       at_target  = (applied_gain == digital_gain);
  wire       step_up    = signed'(digital_gain) > signed'(applied_gain);
  wire       rate_now   = (step_rate == DVP_RATE_NOW) || (step_rate == DVP_RATE_RSVD);
  wire       step_slot  = sample_tick &&
                          ((step_rate == DVP_RATE_ONE) ||
                           (step_rate == DVP_RATE_TWO && half_phase));
  wire [7:0] next_gain  = rate_now              ? digital_gain         :
                          (step_slot && step_up)  ? applied_gain + 8'h01 :
                          (step_slot && !at_target) ? applied_gain - 8'h01 :
                          applied_gain;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_gain <= `DVP_RST_GAIN;
      half_phase   <= 1'b0;
    end else begin
      applied_gain <= next_gain; // RL3 RL11
      half_phase   <= sample_tick ? !half_phase : half_phase; // RL3
    end
  end

  // ****************************************
  // Sample buffer and mono selection
  // ****************************************
  logic [2*SW-1:0] head;
  logic            head_valid;
  wire             take = sample_tick && power_on && head_valid;

  dvp_fifo #(
    .WIDTH (2*SW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_data   ({aud_left, aud_right}),
    .in_valid  (aud_valid),
    .in_ready  (aud_ready),
    .out_data  (head),
    .out_valid (head_valid),
    .out_ready (take)
  );

  wire [SW-1:0] left_s  = head[2*SW-1:SW];
  wire [SW-1:0] right_s = head[SW-1:0];
  wire [SW:0]   lr_sum  = {left_s[SW-1], left_s} + {right_s[SW-1], right_s};
  wire [SW-1:0] mono    = (path_sel == DVP_PATH_LEFT)  ? left_s       :
                          (path_sel == DVP_PATH_RIGHT) ? right_s      :
                          (path_sel == DVP_PATH_AVG)   ? lr_sum[SW:1] :
                          {SW{1'b0}}; // RL2
  wire          silent  = muted || !take; // RL6
  wire [SW-1:0] scaled  = apply_gain(mono, applied_gain); // RL8

  // ****************************************
  // DAC output
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_sample <= {SW{1'b0}};
      dac_valid  <= 1'b0;
      dac_power  <= 1'b0;
    end else begin
      dac_power  <= power_on; // RL1
      dac_valid  <= sample_tick && power_on; // RL1
      if (sample_tick) begin
        dac_sample <= silent ? {SW{1'b0}} : scaled; // RL6
      end
    end
  end
endmodule

// ### verilog/dvp_hst.sv
`timescale 1ns/1ps
`include "dvp_consts.svh"

module dvp_hst (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  dvp_link_if.hst            link,
  input  wire logic [7:0]    sw_addr,
  input  wire logic [7:0]    sw_wdata,
  input  wire logic          sw_wr,
  input  wire logic          sw_rd,
  output dvp_pkg::dvp_byte_t sw_rdata
);
  import dvp_pkg::*;

  // ****************************************
  // Command registers
  // ****************************************
  dvp_byte_t      cmd_addr;
  dvp_byte_t      cmd_wdata;
  dvp_byte_t      cap_rdata;
  logic           refused;
  dvp_hst_state_t state;

  wire busy    = (state != DVP_HST_IDLE);
  wire go      = sw_wr && (sw_addr == `DVP_HOFS_GO) && !busy;
  wire go_wr   = go && sw_wdata[`DVP_GO_WRITE];
  wire go_rd   = go && !sw_wdata[`DVP_GO_WRITE] && sw_wdata[`DVP_GO_READ];

  // ****************************************
  // Keep writes inside the legal encodings
  // ****************************************
  wire       to_path  = (cmd_addr == `DVP_OFS_PATH);
  wire       to_mute  = (cmd_addr == `DVP_OFS_MUTE);
  wire       to_gain  = (cmd_addr == `DVP_OFS_GAIN);
  wire       to_spare = (cmd_addr == `DVP_OFS_SPARE);
  wire       bad_rate = to_path &&
                        (cmd_wdata[`DVP_RATE_HI:`DVP_RATE_LO] == DVP_RATE_RSVD); // RL4
  wire       bad_gain = to_gain &&
                        ((signed'(cmd_wdata) > `DVP_GAIN_MAX) ||
                         (signed'(cmd_wdata) < `DVP_GAIN_MIN)); // RL9
  wire       reject   = bad_rate || bad_gain;
  wire [7:0] clean    = to_path  ? (cmd_wdata & ~(8'h01 << `DVP_BIT_RSVD6)) : // RL5
                        to_mute  ? {4'h0, cmd_wdata[`DVP_BIT_MUTE], `DVP_MUTE_LOW_RST} : // RL7
                        to_spare ? `DVP_RST_SPARE : // RL10
                        cmd_wdata;

  wire [7:0] status   = {6'h00, refused, busy};
  wire [7:0] sw_mux   = (sw_addr == `DVP_HOFS_ADDR)   ? cmd_addr  :
                        (sw_addr == `DVP_HOFS_WDATA)  ? cmd_wdata :
                        (sw_addr == `DVP_HOFS_STATUS) ? status    :
                        (sw_addr == `DVP_HOFS_RDATA)  ? cap_rdata : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_addr  <= 8'h00;
      cmd_wdata <= 8'h00;
      sw_rdata  <= 8'h00;
    end else begin
      if (sw_wr && sw_addr == `DVP_HOFS_ADDR)  cmd_addr  <= sw_wdata;
      if (sw_wr && sw_addr == `DVP_HOFS_WDATA) cmd_wdata <= sw_wdata;
      sw_rdata <= sw_rd ? sw_mux : 8'h00;
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= DVP_HST_IDLE;
      link.addr  <= 8'h00;
      link.wdata <= 8'h00;
      link.wr    <= 1'b0;
      link.rd    <= 1'b0;
      cap_rdata  <= 8'h00;
      refused    <= 1'b0;
    end else begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      unique case (state)
        DVP_HST_IDLE: begin
          if (go_wr) begin
            refused    <= reject;
            link.addr  <= cmd_addr;
            link.wdata <= clean;
            link.wr    <= !reject; // RL4 RL9
          end else if (go_rd) begin
            refused   <= 1'b0;
            link.addr <= cmd_addr;
            link.rd   <= 1'b1;
            state     <= DVP_HST_RDWAIT;
          end
        end
        DVP_HST_RDWAIT: begin
          state <= DVP_HST_RDCAP;
        end
        DVP_HST_RDCAP: begin
          cap_rdata <= link.rdata;
          state     <= DVP_HST_IDLE;
        end
      endcase
    end
  end
endmodule

// ### dv/dvp_chk.sv
`timescale 1ns/1ps
`include "dvp_consts.svh"

module dvp_chk (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata
);
  // ****************************************
  // Shadow copy of the device registers
  // ****************************************
  logic [7:0] shadow [4];
  wire        mapped  = addr >= `DVP_OFS_PATH && addr <= `DVP_OFS_SPARE;
  wire  [1:0] idx     = addr[1:0] + 2'h1;
  wire  [7:0] sel_val = shadow[idx];
  wire        wr_path = wr && addr == `DVP_OFS_PATH;
  wire        wr_mute = wr && addr == `DVP_OFS_MUTE;
  wire        wr_gain = wr && addr == `DVP_OFS_GAIN;
  wire        wr_spr  = wr && addr == `DVP_OFS_SPARE;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow <= '{8'h14, 8'h0C, 8'h00, 8'h00};
    end else if (wr && mapped) begin
      shadow[idx] <= wdata;
    end
  end

  // ****************************************
  // Link checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_map;
    rd && mapped;
  endsequence
  sequence s_rd_gap;
    rd && !mapped;
  endsequence

  property p_one_strobe;
    !(wr && rd);
  endproperty
  property p_rdback;
    s_rd_map |=> rdata == $past(sel_val);
  endproperty
  property p_rd_gap;
    s_rd_gap |=> rdata == 8'h00;
  endproperty
  property p_rd_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  property p_path_d6;
    wr_path |-> !wdata[`DVP_BIT_RSVD6];
  endproperty
  property p_rate;
    wr_path |-> wdata[1:0] != 2'h3;
  endproperty
  property p_mute;
    wr_mute |-> wdata[7:4] == 4'h0 && wdata[2:0] == `DVP_MUTE_LOW_RST;
  endproperty
  property p_gain;
    wr_gain |-> !(wdata >= 8'h31 && wdata <= 8'h80);
  endproperty
  property p_spare;
    wr_spr |-> wdata == 8'h00;
  endproperty

  a_one_strobe: assert property (p_one_strobe) else $error("link wr and rd together");
  a_rdback: assert property (p_rdback) else $error("link read data wrong");
  a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not zero");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_path_d6: assert property (p_path_d6) else $error("path bit 6 written as one");
  a_rate: assert property (p_rate) else $error("reserved step rate written");
  a_mute: assert property (p_mute) else $error("mute reserved bits wrong");
  a_gain: assert property (p_gain) else $error("reserved gain code written");
  a_spare: assert property (p_spare) else $error("spare register written nonzero");
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
`include "dvp_consts.svh"

module tb;
  import dvp_pkg::*;
  logic        sys_clk     = 1'b0;
  logic        rst_n       = 1'b0;
  logic [7:0]  sw_addr     = 8'h00;
  logic [7:0]  sw_wdata    = 8'h00;
  logic        sw_wr       = 1'b0;
  logic        sw_rd       = 1'b0;
  logic [15:0] aud_left    = 16'h0000;
  logic [15:0] aud_right   = 16'h0000;
  logic        aud_valid   = 1'b0;
  logic        sample_tick = 1'b0;
  logic        aud_ready;
  logic [15:0] dac_sample;
  logic        dac_valid;
  logic        dac_power;
  dvp_byte_t   applied_gain;
  dvp_byte_t   sw_rdata;
  logic [7:0]  st;
  logic [31:0] seed        = 32'hB505;
  int          err_count   = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  int          ticks       = 0;

  always #25 sys_clk = ~sys_clk;

  dvp_link_if u_dvp_link_if ();
  dvp_dev #(.SW(16), .DEPTH(16)) u_dvp_dev (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(u_dvp_link_if), .aud_left(aud_left), .aud_right(aud_right),
    .aud_valid(aud_valid), .aud_ready(aud_ready), .sample_tick(sample_tick),
    .dac_sample(dac_sample), .dac_valid(dac_valid), .dac_power(dac_power),
    .applied_gain(applied_gain));
  dvp_hst u_dvp_hst (.sys_clk(sys_clk), .rst_n(rst_n), .link(u_dvp_link_if),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata));
  dvp_chk u_dvp_chk (.sys_clk(sys_clk), .rst_n(rst_n), .addr(u_dvp_link_if.addr),
    .wdata(u_dvp_link_if.wdata), .wr(u_dvp_link_if.wr), .rd(u_dvp_link_if.rd),
    .rdata(u_dvp_link_if.rdata));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction
  function automatic logic [7:0] stepg(input logic [7:0] c, input logic [7:0] t);
    if ($signed(c) < $signed(t)) return c + 8'h01;
    if ($signed(c) > $signed(t)) return c - 8'h01;
    return c;
  endfunction
  function automatic logic [15:0] avg(input logic [15:0] l, input logic [15:0] r);
    logic [16:0] s;
    s = {l[15], l} + {r[15], r};
    return s[16:1];
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic swr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic srd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    @(negedge sys_clk);
    d = sw_rdata;
  endtask
  task automatic go(input logic [7:0] a, input logic [7:0] d, input logic [1:0] op);
    swr(`DVP_HOFS_ADDR, a);
    swr(`DVP_HOFS_WDATA, d);
    swr(`DVP_HOFS_GO, {6'h00, op});
    st = 8'h01;
    for (int i = 0; i < 20 && st[0]; i++) srd(`DVP_HOFS_STATUS, st);
    if (st[0]) chk("busy", 16'h0000, 16'h0001);
  endtask
  task automatic drd(input logic [7:0] a, output logic [7:0] d);
    go(a, 8'h00, 2'h2);
    srd(`DVP_HOFS_RDATA, d);
  endtask
  task automatic wrk(input logic [7:0] a, input logic [7:0] w, input logic [7:0] e);
    logic [7:0] d;
    go(a, w, 2'h1);
    drd(a, d);
    chk("readback", {8'h00, e}, {8'h00, d});
  endtask
  task automatic refuse(input logic [7:0] a, input logic [7:0] w, input logic [7:0] e);
    go(a, w, 2'h1);
    chk("refused", 16'h0001, {15'h0000, st[1]});
    wrk(a, e, e);
  endtask
  task automatic tick();
    @(posedge sys_clk);
    sample_tick <= 1'b1;
    @(posedge sys_clk);
    sample_tick <= 1'b0;
    ticks++;
    @(negedge sys_clk);
  endtask
  task automatic push(input logic [15:0] l, input logic [15:0] r);
    @(posedge sys_clk);
    aud_valid <= 1'b1;
    aud_left <= l;
    aud_right <= r;
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (aud_ready) break;
    end
    aud_valid <= 1'b0;
  endtask
  task automatic final_report();
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0]  d;
    logic [7:0]  t;
    logic [7:0]  g;
    logic [15:0] l;
    logic [15:0] r;
    logic [15:0] e;
    logic [7:0]  rv [4];
    rv = '{8'h14, 8'h0C, 8'h00, 8'h00};
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      drd(8'h3F + 8'(i), d);
      chk("reset", {8'h00, rv[i]}, {8'h00, d});
    end
    drd(8'h43, d);
    chk("unmapped", 16'h0000, {8'h00, d});
    chk("power_off", 16'h0000, {15'h0000, dac_power});
    wrk(8'h40, 8'hF7, 8'h04);
    wrk(8'h40, 8'h08, 8'h0C);
    wrk(8'h42, 8'hA5, 8'h00);
    wrk(8'h3F, 8'h54, 8'h14);
    refuse(8'h3F, 8'h17, 8'h14);
    refuse(8'h41, 8'h31, 8'h00);
    refuse(8'h41, 8'h7F, 8'h00);
    refuse(8'h41, 8'h80, 8'h00);
    for (int i = 0; i < 16; i++) push(16'(i), 16'(~i));
    tick();
    chk("full", 16'h0000, {15'h0000, aud_ready});
    chk("valid_off", 16'h0000, {15'h0000, dac_valid});
    go(8'h40, 8'h04, 2'h1);
    go(8'h3F, 8'h94, 2'h1);
    chk("power_on", 16'h0001, {15'h0000, dac_power});
    for (int i = 0; i < 17; i++) begin
      tick();
      chk("drain", (i < 16) ? 16'(i) : 16'h0000, dac_sample);
      chk("valid", 16'h0001, {15'h0000, dac_valid});
    end
    for (int p = 0; p < 8; p++) begin
      go(8'h3F, {2'h2, 2'(p), 4'h6}, 2'h1);
      go(8'h40, p[2] ? 8'h0C : 8'h04, 2'h1);
      l = rnd();
      r = rnd();
      push(l, r);
      tick();
      e = (p[2] || p[1:0] == 2'h0) ? 16'h0000 :
          (p[1:0] == 2'h1) ? l : (p[1:0] == 2'h2) ? r : avg(l, r);
      chk("dac", e, dac_sample);
    end
    g = 8'h00;
    for (int k = 0; k < 2; k++) begin
      go(8'h3F, {6'h25, 2'(k)}, 2'h1);
      t = 8'(rnd() % 16'h000D) - 8'h06;
      go(8'h41, t, 2'h1);
      for (int i = 0; i < 14; i++) begin
        if (k == 0 || ticks % 2 == 1) g = stepg(g, t);
        tick();
        chk("step", {8'h00, g}, {8'h00, applied_gain});
      end
    end
    go(8'h3F, 8'h96, 2'h1);
    go(8'h41, 8'h30, 2'h1);
    chk("now_max", 16'h0030, {8'h00, applied_gain});
    go(8'h40, 8'h04, 2'h1);
    push(16'h0123, 16'h0000);
    tick();
    chk("gain_max", 16'h1230, dac_sample);
    push(16'h4000, 16'h0000);
    tick();
    chk("gain_sat", 16'h7FFF, dac_sample);
    go(8'h41, 8'hF4, 2'h1);
    push(16'h0124, 16'h0000);
    tick();
    chk("gain_half", 16'h0092, dac_sample);
    go(8'h41, 8'h81, 2'h1);
    chk("now_min", 16'h0081, {8'h00, applied_gain});
    final_report();
  end
endmodule
